// >>> design/pmc_ctrl.sv
// Power mode controller: AXI4-Lite registers, power state sequencing, regulator controls
`timescale 1ns/1ps
module pmc_ctrl #(
  parameter int USB_IDLE_CYCLES = pmc_pkg::USB_IDLE_CYC
) (
  input  wire logic                          CORE_CLK,
  input  wire logic                          NRST,
  input  wire logic                          AWVALID,
  output logic                               AWREADY,
  input  wire logic [pmc_pkg::ADDR_W-1:0]    AWADDR,
  input  wire logic                          WVALID,
  output logic                               WREADY,
  input  wire logic [pmc_pkg::DATA_W-1:0]    WDATA,
  input  wire logic [pmc_pkg::STRB_W-1:0]    WSTRB,
  output logic                               BVALID,
  input  wire logic                          BREADY,
  output logic      [1:0]                    BRESP,
  input  wire logic                          ARVALID,
  output logic                               ARREADY,
  input  wire logic [pmc_pkg::ADDR_W-1:0]    ARADDR,
  output logic                               RVALID,
  input  wire logic                          RREADY,
  output logic      [pmc_pkg::DATA_W-1:0]    RDATA,
  output logic      [1:0]                    RRESP,
  input  wire pmc_pkg::pmc_sense_t           SENSE,
  output pmc_pkg::pmc_pwr_t                  PWR
);
  import pmc_pkg::*;

  logic                 rst_meta_q;
  logic                 rst_n_q;
  pmc_sense_t           sense_s;
  logic                 aw_got_q;
  logic                 w_got_q;
  logic [ADDR_W-1:0]    awaddr_q;
  logic [DATA_W-1:0]    wdata_q;
  logic [STRB_W-1:0]    wstrb_q;
  logic [DATA_W-1:0]    wmask;
  logic                 aw_hs;
  logic                 w_hs;
  logic                 ar_hs;
  logic                 wr_go;
  logic                 aw_got_d;
  logic                 w_got_d;
  logic                 bvalid_d;
  logic                 rvalid_d;
  logic                 wr_ctrl;
  logic                 wr_wake;
  logic                 wr_evt;
  logic                 wr_map;
  logic                 rd_map;
  logic [DATA_W-1:0]    rd_val;
  pmc_ctrl_t            ctrl_q;
  pmc_ctrl_t            ctrl_w;
  pmc_ctrl_t            ctrl_c;
  logic [WAKE_EN_W-1:0] wake_en_q;
  logic [EVT_W-1:0]     evt_q;
  logic [EVT_W-1:0]     evt_set;
  logic [EVT_W-1:0]     evt_clr;
  pmc_stat_t            stat;
  pmc_state_t           state_q;
  pmc_state_t           state_d;
  logic                 tgt_susp_q;
  logic                 temp_seen_q;
  logic                 stby_p;
  logic                 susp_p;
  logic                 wake_hit;
  logic                 blocked;
  logic                 temp_any;
  logic                 temp_exit;
  logic                 ref_s;
  logic                 ref_u;
  logic                 lp_d;
  logic                 idle_hit;
  pmc_pwr_t             pwr_d;

  // Reset is asserted at once and released through two flops
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Status pins come from other power domains
  pmc_sync #(
    .W ($bits(pmc_sense_t))
  ) u_sync (
    .clk   (CORE_CLK),
    .rst_n (rst_n_q),
    .d     (SENSE),
    .q     (sense_s)
  );

  pmc_idle_timer #(
    .LIMIT (USB_IDLE_CYCLES)
  ) u_idle (
    .clk   (CORE_CLK),
    .rst_n (rst_n_q),
    .act   (sense_s.usb_act),
    .hit   (idle_hit)
  );

  // Bus handshakes; address and data may arrive in either order
  assign aw_hs    = AWVALID && AWREADY;
  assign w_hs     = WVALID && WREADY;
  assign ar_hs    = ARVALID && ARREADY;
  assign wr_go    = aw_got_q && w_got_q;
  assign aw_got_d = aw_hs || (aw_got_q && !wr_go);
  assign w_got_d  = w_hs || (w_got_q && !wr_go);
  assign bvalid_d = wr_go || (BVALID && !BREADY);
  assign rvalid_d = ar_hs || (RVALID && !RREADY);

  // Byte lane mask from the write strobes
  for (genvar i = 0; i < STRB_W; i++) begin : g_lane
    assign wmask[i*8 +: 8] = {8{wstrb_q[i]}};
  end

  // Write channel: hold each half until both are in, then answer
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      AWREADY  <= 1'b0;
      WREADY   <= 1'b0;
      BVALID   <= 1'b0;
      BRESP    <= RESP_OKAY;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      AWREADY  <= !aw_got_d && !bvalid_d;
      WREADY   <= !w_got_d && !bvalid_d;
      BVALID   <= bvalid_d;
      if (aw_hs) begin
        awaddr_q <= AWADDR;
      end
      if (w_hs) begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (wr_go) begin
        BRESP <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Write decode; the status register accepts and ignores writes
  assign wr_ctrl = wr_go && (awaddr_q == OFS_CTRL);
  assign wr_wake = wr_go && (awaddr_q == OFS_WAKE);
  assign wr_evt  = wr_go && (awaddr_q == OFS_EVT);
  assign wr_map  = (awaddr_q == OFS_CTRL) || (awaddr_q == OFS_WAKE) ||
                   (awaddr_q == OFS_STAT) || (awaddr_q == OFS_EVT);

  // Read mux; unmapped reads return zero with an error answer
  always_comb begin
    rd_map = 1'b1;
    case (ARADDR)
      OFS_CTRL: rd_val = ctrl_q;
      OFS_WAKE: rd_val = DATA_W'(wake_en_q);
      OFS_STAT: rd_val = stat;
      OFS_EVT:  rd_val = DATA_W'(evt_q);
      default: begin
        rd_val = '0;
        rd_map = 1'b0;
      end
    endcase
  end

  // Read channel: one answer per address, next address after it is taken
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= RESP_OKAY;
    end else begin
      ARREADY <= !rvalid_d;
      RVALID  <= rvalid_d;
      if (ar_hs) begin
        RDATA <= rd_val;
        RRESP <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Control word after byte merge; request bits are strobes, never stored
  assign ctrl_w = (ctrl_q & ~wmask) | (wdata_q & wmask);
  assign stby_p = wr_ctrl && ctrl_w.stby_req;
  assign susp_p = wr_ctrl && ctrl_w.susp_req;

  always_comb begin
    ctrl_c          = ctrl_w;
    ctrl_c.stby_req = 1'b0;
    ctrl_c.susp_req = 1'b0;
    ctrl_c.rsv0     = '0;
    ctrl_c.rsv1     = '0;
    // Only five output levels exist; larger codes are held at the top one
    if (ctrl_w.tx_level > TX_LVL_MAX) begin
      ctrl_c.tx_level = TX_LVL_MAX;
    end
  end

  // Control and wake enable registers
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q    <= CTRL_RST;
      wake_en_q <= WAKE_EN_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_c;
      end
      if (wr_wake) begin
        wake_en_q <= (wake_en_q & ~wmask[WAKE_EN_W-1:0]) |
                     (wdata_q[WAKE_EN_W-1:0] & wmask[WAKE_EN_W-1:0]);
      end
    end
  end

  // Entry checks shared by standby and suspend
  assign wake_hit  = |(sense_s.wake_evt & wake_en_q[WAKE_N-1:0]);
  assign blocked   = sense_s.host_busy || wake_hit ||
                     (wake_en_q[WK_FIELD] && !sense_s.field_det_on) ||
                     !sense_s.pad_supply_rail_ok;
  assign temp_any  = |sense_s.temp_over;
  assign temp_exit = wake_en_q[WK_TEMP] && temp_seen_q;

  // Refused at request time or again when card shutdown completes
  assign ref_s = blocked && ((state_q == ST_ACTIVE && stby_p) ||
                 (state_q == ST_DEACT && sense_s.ct_deact_done && !tgt_susp_q));
  assign ref_u = blocked && ((state_q == ST_ACTIVE && susp_p && !stby_p) ||
                 (state_q == ST_DEACT && sense_s.ct_deact_done && tgt_susp_q));

  // Power state sequencing; power-down request overrides everything
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE: begin
        if ((stby_p || susp_p) && !blocked) begin
          state_d = ST_DEACT;
        end
      end
      ST_DEACT: begin
        if (sense_s.ct_deact_done) begin
          if (blocked) begin
            state_d = ST_ACTIVE;
          end else if (tgt_susp_q) begin
            state_d = ST_SUSPEND;
          end else begin
            state_d = ST_STANDBY;
          end
        end
      end
      ST_STANDBY: begin
        if (!temp_any && (wake_hit || temp_exit)) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_SUSPEND: begin
        if (wake_hit) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_HPD: begin
        if (!sense_s.hpd_req) begin
          state_d = ST_ACTIVE;
        end
      end
      default: state_d = ST_HPD;
    endcase
    if (sense_s.hpd_req) begin
      state_d = ST_HPD;
    end
  end

  // State, target and overheat memory
  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q     <= ST_ACTIVE;
      tgt_susp_q  <= 1'b0;
      temp_seen_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      // Standby wins when both requests land together
      if (state_q == ST_ACTIVE && (stby_p || susp_p)) begin
        tgt_susp_q <= !stby_p;
      end
      // Remembers an overheat so a cool-down can end standby
      temp_seen_q <= (state_d == ST_STANDBY) && (temp_seen_q || temp_any);
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_comb begin
    evt_set           = '0;
    evt_set[EVT_USB]  = idle_hit;
    evt_set[EVT_SREF] = ref_s;
    evt_set[EVT_UREF] = ref_u;
    evt_clr = wr_evt ? (wdata_q[EVT_W-1:0] & wmask[EVT_W-1:0]) : '0;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      evt_q <= '0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  // Status word
  always_comb begin
    stat            = '0;
    stat.pstate     = PWR.pstate;
    stat.deact_busy = (state_q == ST_DEACT);
    stat.pad_gnd    = sense_s.pad_regulator_output_gnd;
    stat.temp_over  = sense_s.temp_over;
  end

  // Controls follow the next state so they register together with it
  assign lp_d = (state_d == ST_STANDBY) || (state_d == ST_SUSPEND);

  always_comb begin
    pwr_d = '0;
    case (state_d)
      ST_STANDBY: pwr_d.pstate = PS_STBY;
      ST_SUSPEND: pwr_d.pstate = PS_SUSP;
      ST_HPD:     pwr_d.pstate = PS_HPD;
      default:    pwr_d.pstate = PS_ACT;
    endcase
    pwr_d.low_freq_osc_clock_sel = lp_d;
    pwr_d.hf_clk_stop = (state_d == ST_SUSPEND) || (state_d == ST_HPD);
    pwr_d.main_core_regulator_lp = lp_d || (state_d == ST_HPD);
    // Grounded output means an external pad supply, so the regulator must stay off
    if (sense_s.pad_regulator_output_gnd || state_d == ST_HPD) begin
      pwr_d.pad_supply_regulator_mode = PAD_OFF;
    end else if (state_d == ST_STANDBY) begin
      pwr_d.pad_supply_regulator_mode = ctrl_q.pad_stby;
    end else if (state_d == ST_SUSPEND) begin
      pwr_d.pad_supply_regulator_mode = PAD_LP;
    end else begin
      pwr_d.pad_supply_regulator_mode = PAD_ACT;
    end
    pwr_d.transmitter_supply_regulator_level = ctrl_q.tx_level;
    pwr_d.transmitter_supply_regulator_en = !ctrl_q.tx_off && (state_d != ST_HPD);
    pwr_d.temp_lim0 = ctrl_q.temp_lim0;
    pwr_d.temp_lim1 = ctrl_q.temp_lim1;
    // Peripheral clocks only run while the core is awake
    if (state_d == ST_ACTIVE || state_d == ST_DEACT) begin
      pwr_d.sysclk_div    = ctrl_q.sysclk_div;
      pwr_d.periph_clk_en = ctrl_q.pclk_en;
    end
    pwr_d.wake_src_en  = (state_d == ST_HPD) ? '0 : wake_en_q;
    pwr_d.ct_deact_req = (state_d == ST_DEACT);
    pwr_d.usb_idle_irq = evt_q[EVT_USB] || idle_hit;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PWR <= '0;
    end else begin
      PWR <= pwr_d;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n_q);

  property p_no_direct_stby;
    state_q == ST_ACTIVE |=> state_q != ST_STANDBY;
  endproperty
  a_no_direct_stby: assert property (p_no_direct_stby) else $error("standby skipped");

  property p_deact_req;
    state_q == ST_DEACT |-> PWR.ct_deact_req && stat.deact_busy;
  endproperty
  a_deact_req: assert property (p_deact_req) else $error("card shutdown not requested");

  property p_no_direct_susp;
    state_q == ST_ACTIVE |=> state_q != ST_SUSPEND;
  endproperty
  a_no_direct_susp: assert property (p_no_direct_susp) else $error("suspend skipped");

  property p_stby_refuse;
    (state_q == ST_ACTIVE && stby_p && blocked && !sense_s.hpd_req)
      |=> state_q == ST_ACTIVE ##0 evt_q[EVT_SREF];
  endproperty
  a_stby_refuse: assert property (p_stby_refuse) else $error("standby refusal lost");

  property p_susp_refuse;
    (state_q == ST_ACTIVE && susp_p && !stby_p && blocked && !sense_s.hpd_req)
      |=> state_q == ST_ACTIVE ##0 evt_q[EVT_UREF];
  endproperty
  a_susp_refuse: assert property (p_susp_refuse) else $error("suspend refusal lost");

  property p_stby_clk;
    state_q == ST_STANDBY |-> PWR.low_freq_osc_clock_sel && PWR.pstate == PS_STBY;
  endproperty
  a_stby_clk: assert property (p_stby_clk) else $error("standby clock wrong");

  property p_stby_reg;
    state_q == ST_STANDBY |-> PWR.main_core_regulator_lp && PWR.periph_clk_en == '0;
  endproperty
  a_stby_reg: assert property (p_stby_reg) else $error("main regulator not low-power");

  property p_temp_hold;
    (state_q == ST_STANDBY && temp_any && !sense_s.hpd_req) |=> state_q == ST_STANDBY;
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("left standby while hot");

  property p_susp_clk;
    state_q == ST_SUSPEND |-> PWR.hf_clk_stop && PWR.low_freq_osc_clock_sel &&
      PWR.pad_supply_regulator_mode != PAD_ACT;
  endproperty
  a_susp_clk: assert property (p_susp_clk) else $error("suspend clocks or pad wrong");

  property p_pad_gnd;
    sense_s.pad_regulator_output_gnd |=> PWR.pad_supply_regulator_mode == PAD_OFF;
  endproperty
  a_pad_gnd: assert property (p_pad_gnd) else $error("pad regulator on with grounded output");

  property p_tx_level;
    PWR.transmitter_supply_regulator_level <= TX_LVL_MAX;
  endproperty
  a_tx_level: assert property (p_tx_level) else $error("transmitter level out of range");

  property p_idle_hold;
    (evt_q[EVT_USB] && !evt_clr[EVT_USB]) |=> evt_q[EVT_USB] ##1 PWR.usb_idle_irq;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle flag dropped");

  c_standby: cover property (state_q == ST_DEACT && state_d == ST_STANDBY);
  c_suspend: cover property (state_q == ST_DEACT && state_d == ST_SUSPEND);
  c_refused: cover property ($rose(evt_q[EVT_SREF]));
  c_idle:    cover property ($rose(evt_q[EVT_USB]));
endmodule : pmc_ctrl

// >>> design/pmc_pkg.sv
// Power mode controller: register map, encodings, timing and carrier types
// Functional notes
// - Chip is always in one of four states: power-down, standby, suspend, active.
// - Active: all peripherals usable, clocks set by register, unused ones disabled.
// - Standby is entered only on a firmware request, never autonomously.
// - Contact card is deactivated before standby takes effect.
// - Standby refused on host transfer, live wake, field detector off, no pad rail.
// - Standby runs remaining logic from the low-frequency oscillator clock.
// - Standby keeps main regulator low-power and enabled wake sources powered.
// - Setting picks pad regulator standby mode; low-power after reset.
// - Standby held while either temperature sensor is over its limit.
// - Interrupt raised after USB idle for more than 3 ms.
// - Suspend is entered only on a firmware request.
// - Contact card is deactivated before suspend takes effect.
// - Suspend blocked on host transfer, live wake, field detector off, no pad rail.
// - Suspend stops every clock source except the low-frequency oscillator.
// - Pad regulator goes low-power automatically in suspend; in standby it follows the setting.
// - Pad regulator off when its output is tied to ground.
// - Transmitter regulator level from five settings, 3.0 V to 4.75 V; can be off.
// - Each wake source has its own enable; only enabled sources wake.
package pmc_pkg;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int STRB_W    = 4;
  localparam int WAKE_N    = 7;
  localparam int WAKE_EN_W = 8;
  localparam int EVT_W     = 3;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WAKE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EVT  = 8'h0C;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Wake enable bits and event bits
  localparam int WK_FIELD = 0;
  localparam int WK_TEMP  = 7;
  localparam int EVT_USB  = 0;
  localparam int EVT_SREF = 1;
  localparam int EVT_UREF = 2;
  // Reported power state and pad regulator modes
  localparam logic [1:0] PS_HPD  = 2'h0;
  localparam logic [1:0] PS_STBY = 2'h1;
  localparam logic [1:0] PS_SUSP = 2'h2;
  localparam logic [1:0] PS_ACT  = 2'h3;
  localparam logic [1:0] PAD_ACT = 2'h0;
  localparam logic [1:0] PAD_LP  = 2'h1;
  localparam logic [1:0] PAD_OFF = 2'h2;
  // Level codes 0..4 give 3.0, 3.3, 3.6, 4.5 and 4.75 V
  localparam logic [2:0] TX_LVL_MAX = 3'h4;
  localparam logic [WAKE_EN_W-1:0] WAKE_EN_RST = 8'h00;
  localparam logic [DATA_W-1:0]    CTRL_RST    = 32'h00FF_0004;
  // USB idle time
  localparam int CLK_MHZ      = 125;
  localparam int USB_IDLE_MS  = 3;
  localparam int USB_IDLE_CYC = USB_IDLE_MS * 1000 * CLK_MHZ;
  localparam int IDLE_CNT_W   = 20;

  typedef enum logic [2:0] {ST_HPD, ST_ACTIVE, ST_DEACT, ST_STANDBY, ST_SUSPEND} pmc_state_t;

  typedef struct packed {
    logic [7:0] rsv0;
    logic [7:0] pclk_en;
    logic [1:0] rsv1;
    logic [1:0] sysclk_div;
    logic [1:0] temp_lim1;
    logic [1:0] temp_lim0;
    logic       tx_off;
    logic [2:0] tx_level;
    logic [1:0] pad_stby;
    logic       susp_req;
    logic       stby_req;
  } pmc_ctrl_t;

  typedef struct packed {
    logic [25:0] rsv;
    logic [1:0]  temp_over;
    logic        pad_gnd;
    logic        deact_busy;
    logic [1:0]  pstate;
  } pmc_stat_t;

  typedef struct packed {
    logic              host_busy;
    logic              field_det_on;
    logic              pad_supply_rail_ok;
    logic              pad_regulator_output_gnd;
    logic              usb_act;
    logic              ct_deact_done;
    logic              hpd_req;
    logic [1:0]        temp_over;
    logic [WAKE_N-1:0] wake_evt;
  } pmc_sense_t;

  typedef struct packed {
    logic [1:0]           pstate;
    logic                 low_freq_osc_clock_sel;
    logic                 hf_clk_stop;
    logic                 main_core_regulator_lp;
    logic [1:0]           pad_supply_regulator_mode;
    logic [2:0]           transmitter_supply_regulator_level;
    logic                 transmitter_supply_regulator_en;
    logic [1:0]           temp_lim0;
    logic [1:0]           temp_lim1;
    logic [1:0]           sysclk_div;
    logic [7:0]           periph_clk_en;
    logic [WAKE_EN_W-1:0] wake_src_en;
    logic                 ct_deact_req;
    logic                 usb_idle_irq;
  } pmc_pwr_t;
endpackage : pmc_pkg

// >>> design/pmc_sync.sv
// Two-flop synchroniser for pin-level status inputs
`timescale 1ns/1ps
module pmc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : pmc_sync

// >>> design/pmc_idle_timer.sv
// USB idle timer: one pulse once the port has been quiet past the limit
`timescale 1ns/1ps
module pmc_idle_timer #(
  parameter int LIMIT = pmc_pkg::USB_IDLE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic act,
  output logic      hit
);
  import pmc_pkg::*;
  localparam logic [IDLE_CNT_W-1:0] LIM = IDLE_CNT_W'(LIMIT);

  logic [IDLE_CNT_W-1:0] cnt_q;

  // Saturates one past the limit so a long silence fires only once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (act) begin
      cnt_q <= '0;
    end else if (cnt_q <= LIM) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Quiet for more than the limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit <= 1'b0;
    end else begin
      hit <= !act && (cnt_q == LIM);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_hit_cause;
    hit |-> ($past(cnt_q) == LIM) && !$past(act);
  endproperty
  a_hit_cause: assert property (p_hit_cause) else $error("idle pulse without full quiet");

  property p_restart;
    act |=> (cnt_q == '0) && !hit;
  endproperty
  a_restart: assert property (p_restart) else $error("activity did not restart idle");
endmodule : pmc_idle_timer

// >>> sim/test_pmc_ctrl.sv
// Self-checking testbench for the power mode controller
`timescale 1ns/1ps
module test_pmc_ctrl;
  import pmc_pkg::*;
  logic              clk = 0;
  logic              nrst = 0;
  logic              awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic              awr, wrd, bv, arr, rv;
  logic [ADDR_W-1:0] aa = '0, ra = '0;
  logic [DATA_W-1:0] wd = '0, rdat, d;
  logic [1:0]        bq, rq, r;
  pmc_sense_t        sense;
  pmc_pwr_t          pwr;
  int                err_total = 0;
  int                num_checks = 0;
  // Short idle limit keeps the quiet-port run brief
  pmc_ctrl #(.USB_IDLE_CYCLES(20)) u_pmc_ctrl (.CORE_CLK(clk), .NRST(nrst),
    .AWVALID(awv), .AWREADY(awr), .AWADDR(aa), .WVALID(wv), .WREADY(wrd), .WDATA(wd),
    .WSTRB(4'hF), .BVALID(bv), .BREADY(br), .BRESP(bq), .ARVALID(arv), .ARREADY(arr),
    .ARADDR(ra), .RVALID(rv), .RREADY(rr), .RDATA(rdat), .RRESP(rq), .SENSE(sense), .PWR(pwr));
  always #4 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Address and data offered together; each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    aa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    br <= 1;
    forever begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      if (bv) begin
        r = bq;
        br <= 0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ra <= a;
    arv <= 1;
    rr <= 1;
    forever begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv) begin
        d = rdat;
        r = rq;
        rr <= 0;
        break;
      end
    end
  endtask : rd
  task automatic wps(input logic [1:0] p);
    repeat (12) if (pwr.pstate !== p) @(posedge clk);
    chk("pstate", 32'(pwr.pstate), 32'(p));
  endtask : wps
  // Refused request must flag the event and leave the chip active
  task automatic t_ref(input logic [31:0] q, input logic [31:0] ev);
    wr(OFS_CTRL, CTRL_RST | q);
    chk("bresp", 32'(r), 32'(RESP_OKAY));
    rd(OFS_EVT);
    chk("evt", d, ev);
    chk("pst", 32'(pwr.pstate), 32'(PS_ACT));
    wr(OFS_EVT, ev);
  endtask : t_ref
  task automatic t_stby;
    wr(OFS_WAKE, 32'h0000_0002);
    wr(OFS_CTRL, CTRL_RST | 32'h0000_0001);
    repeat (10) if (pwr.ct_deact_req !== 1'b1) @(posedge clk);
    chk("deact", 32'(pwr.ct_deact_req), 32'h0000_0001);
    chk("pre", 32'(pwr.pstate), 32'(PS_ACT));
    sense.ct_deact_done <= 1;
    wps(PS_STBY);
    chk("lfo", 32'(pwr.low_freq_osc_clock_sel), 32'h0000_0001);
    chk("mlp", 32'(pwr.main_core_regulator_lp), 32'h0000_0001);
    chk("pad", 32'(pwr.pad_supply_regulator_mode), 32'(PAD_LP));
    sense.ct_deact_done <= 0;
    repeat (3) @(posedge clk);
    sense.wake_evt <= 7'h04;
    repeat (8) @(posedge clk);
    chk("dis", 32'(pwr.pstate), 32'(PS_STBY));
    sense.temp_over <= 2'b01;
    repeat (3) @(posedge clk);
    sense.wake_evt <= 7'h06;
    repeat (8) @(posedge clk);
    chk("hot", 32'(pwr.pstate), 32'(PS_STBY));
    sense.temp_over <= 2'b00;
    wps(PS_ACT);
    sense.wake_evt <= 7'h00;
  endtask : t_stby
  // A blip mid-way must restart the quiet count
  task automatic t_usb;
    sense.usb_act <= 0;
    repeat (15) @(posedge clk);
    sense.usb_act <= 1;
    @(posedge clk);
    sense.usb_act <= 0;
    repeat (18) @(posedge clk);
    chk("early", 32'(pwr.usb_idle_irq), 32'h0000_0000);
    repeat (20) if (pwr.usb_idle_irq !== 1'b1) @(posedge clk);
    chk("irq", 32'(pwr.usb_idle_irq), 32'h0000_0001);
    wr(OFS_EVT, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("clr", 32'(pwr.usb_idle_irq), 32'h0000_0000);
    sense.usb_act <= 1;
  endtask : t_usb
  // Suspend stops fast clocks; tx level clamps; grounded pad output forces regulator off
  task automatic t_susp;
    wr(OFS_CTRL, CTRL_RST | 32'h0000_00F2);
    rd(OFS_CTRL);
    chk("txc", d, CTRL_RST | 32'h0000_00C0);
    sense.ct_deact_done <= 1;
    wps(PS_SUSP);
    chk("hfs", 32'(pwr.hf_clk_stop), 32'h0000_0001);
    chk("lfs", 32'(pwr.low_freq_osc_clock_sel), 32'h0000_0001);
    chk("pds", 32'(pwr.pad_supply_regulator_mode), 32'(PAD_LP));
    chk("txl", 32'(pwr.transmitter_supply_regulator_level), 32'(TX_LVL_MAX));
    chk("txe", 32'(pwr.transmitter_supply_regulator_en), 32'h0000_0000);
    sense.ct_deact_done <= 0;
    sense.pad_regulator_output_gnd <= 1;
    repeat (5) @(posedge clk);
    chk("gnd", 32'(pwr.pad_supply_regulator_mode), 32'(PAD_OFF));
    sense.pad_regulator_output_gnd <= 0;
    sense.wake_evt <= 7'h02;
    wps(PS_ACT);
    sense.wake_evt <= 7'h00;
  endtask : t_susp
  // Cool-down after an overheat ends standby when that wake source is enabled
  task automatic t_cool;
    wr(OFS_WAKE, 32'h0000_0080);
    wr(OFS_CTRL, CTRL_RST | 32'h0000_0001);
    sense.ct_deact_done <= 1;
    wps(PS_STBY);
    sense.ct_deact_done <= 0;
    sense.temp_over <= 2'b10;
    repeat (8) @(posedge clk);
    chk("hot1", 32'(pwr.pstate), 32'(PS_STBY));
    sense.temp_over <= 2'b00;
    wps(PS_ACT);
  endtask : t_cool
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    sense = '0;
    sense.pad_supply_rail_ok = 1;
    sense.field_det_on = 1;
    sense.usb_act = 1;
    repeat (2) @(posedge clk);
    nrst <= 1;
    repeat (5) @(posedge clk);
    rd(OFS_CTRL);
    chk("ctrl", d, CTRL_RST);
    chk("act", 32'(pwr.pstate), 32'(PS_ACT));
    chk("pclk", 32'(pwr.periph_clk_en), 32'h0000_00FF);
    rd(8'h10);
    chk("rresp", 32'(r), 32'(RESP_SLVERR));
    wr(8'h10, 32'h0000_0000);
    chk("wresp", 32'(r), 32'(RESP_SLVERR));
    sense.host_busy <= 1;
    repeat (3) @(posedge clk);
    t_ref(32'h0000_0001, 32'h0000_0002);
    sense.host_busy <= 0;
    sense.pad_supply_rail_ok <= 0;
    repeat (3) @(posedge clk);
    t_ref(32'h0000_0002, 32'h0000_0004);
    sense.pad_supply_rail_ok <= 1;
    repeat (3) @(posedge clk);
    wr(OFS_WAKE, 32'h0000_0001);
    sense.field_det_on <= 0;
    repeat (3) @(posedge clk);
    t_ref(32'h0000_0001, 32'h0000_0002);
    sense.field_det_on <= 1;
    t_stby;
    t_usb;
    t_susp;
    t_cool;
    sense.hpd_req <= 1;
    wps(PS_HPD);
    sense.hpd_req <= 0;
    wps(PS_ACT);
    end_sim;
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #20us;
    err_total++;
    end_sim;
  end
endmodule : test_pmc_ctrl
